//--- cfsr_axil_slave.sv
// axi4-lite slave, one write and one read outstanding
`timescale 1ns/100ps
`include "cfsr_map.svh"
module cfsr_axil_slave (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // write channels
  input  wire logic                    awvalid,
  input  wire logic [`CFSR_ADDR_W-1:0] awaddr,
  output logic                         awready_q,
  input  wire logic                    wvalid,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         wready_q,
  output logic                         bvalid_q,
  output logic [1:0]                   bresp_q,
  input  wire logic                    bready,
  // read channels
  input  wire logic                    arvalid,
  input  wire logic [`CFSR_ADDR_W-1:0] araddr,
  output logic                         arready_q,
  output logic                         rvalid_q,
  output logic [31:0]                  rdata_q,
  output logic [1:0]                   rresp_q,
  input  wire logic                    rready,
  // register side
  cfsr_regbus_if.bus                   rb
);
  logic aw_full_q;
  logic w_full_q;
  logic [`CFSR_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  assign rb.wr_en   = aw_full_q & w_full_q;
  assign rb.wr_addr = awaddr_q;
  assign rb.wr_data = wdata_q;
  assign rb.wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign rb.rd_addr = araddr;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CFSR_RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        wready_q <= 1'b0;
      end
      if (rb.wr_en) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= rb.wr_hit ? `CFSR_RESP_OKAY : `CFSR_RESP_SLVERR;
      end
      // ready returns only after the response, keeping one write in flight
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= `CFSR_RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rb.rd_hit ? rb.rd_data : 32'h0;
      rresp_q   <= rb.rd_hit ? `CFSR_RESP_OKAY : `CFSR_RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end
endmodule : cfsr_axil_slave

//--- cfsr_fault_recorder.sv
// context bank fault status recorder with axi4-lite registers
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "cfsr_map.svh"
module cfsr_fault_recorder #(
  parameter int unsigned BANK_IDX_W = 8,
  parameter bit          HAS_LOCK   = 1'b1,
  parameter bit          HAS_MATCH  = 1'b1,
  parameter bit          HAS_EXT    = 1'b1
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // axi4-lite write
  input  wire logic                    s_axil_awvalid,
  input  wire logic [`CFSR_ADDR_W-1:0] s_axil_awaddr,
  output logic                         s_axil_awready,
  input  wire logic                    s_axil_wvalid,
  input  wire logic [31:0]             s_axil_wdata,
  input  wire logic [3:0]              s_axil_wstrb,
  output logic                         s_axil_wready,
  output logic                         s_axil_bvalid,
  output logic [1:0]                   s_axil_bresp,
  input  wire logic                    s_axil_bready,
  // axi4-lite read
  input  wire logic                    s_axil_arvalid,
  input  wire logic [`CFSR_ADDR_W-1:0] s_axil_araddr,
  output logic                         s_axil_arready,
  output logic                         s_axil_rvalid,
  output logic [31:0]                  s_axil_rdata,
  output logic [1:0]                   s_axil_rresp,
  input  wire logic                    s_axil_rready,
  // fault report from the translation logic
  input  wire logic                    fault_valid,
  input  wire logic [`CFSR_FLAG_MSB:1] fault_kind,
  input  wire logic                    fault_stall,
  input  wire logic                    fault_async,
  input  wire logic                    fault_walk,
  input  wire logic [BANK_IDX_W-1:0]   fault_stage_one_bank,
  // stall control toward the translation logic
  output logic                         context_stalled,
  output logic                         resume_pulse,
  output logic                         resume_terminate,
  output logic                         retry_pulse
);
  // ****************************************************************
  // bus slave and decode
  // ****************************************************************
  cfsr_regbus_if rb ();

  cfsr_axil_slave u_slave (
    .clock     (clock),
    .rst_n     (rst_n),
    .awvalid   (s_axil_awvalid),
    .awaddr    (s_axil_awaddr),
    .awready_q (s_axil_awready),
    .wvalid    (s_axil_wvalid),
    .wdata     (s_axil_wdata),
    .wstrb     (s_axil_wstrb),
    .wready_q  (s_axil_wready),
    .bvalid_q  (s_axil_bvalid),
    .bresp_q   (s_axil_bresp),
    .bready    (s_axil_bready),
    .arvalid   (s_axil_arvalid),
    .araddr    (s_axil_araddr),
    .arready_q (s_axil_arready),
    .rvalid_q  (s_axil_rvalid),
    .rdata_q   (s_axil_rdata),
    .rresp_q   (s_axil_rresp),
    .rready    (s_axil_rready),
    .rb        (rb.bus)
  );

  function automatic cfsr_pkg::cfsr_sel_t reg_sel(input logic [`CFSR_ADDR_W-1:0] addr);
    unique case (addr)
      `CFSR_OFF_STATUS:  reg_sel = cfsr_pkg::CFSR_SEL_STATUS;
      `CFSR_OFF_RESTORE: reg_sel = cfsr_pkg::CFSR_SEL_RESTORE;
      `CFSR_OFF_SYN:     reg_sel = cfsr_pkg::CFSR_SEL_SYN;
      `CFSR_OFF_RESUME:  reg_sel = cfsr_pkg::CFSR_SEL_RESUME;
      `CFSR_OFF_CFG:     reg_sel = cfsr_pkg::CFSR_SEL_CFG;
      `CFSR_OFF_SBC:     reg_sel = cfsr_pkg::CFSR_SEL_SBC;
      `CFSR_OFF_CTL:     reg_sel = cfsr_pkg::CFSR_SEL_CTL;
      default:           reg_sel = cfsr_pkg::CFSR_SEL_NONE;
    endcase
  endfunction : reg_sel

  cfsr_pkg::cfsr_sel_t wsel;
  cfsr_pkg::cfsr_sel_t rsel;
  logic [31:0] wval;
  logic        status_wr;
  logic        restore_wr;
  logic        syn_wr;
  logic        resume_wr;
  logic        cfg_wr;
  logic        sbc_wr;
  logic        ctl_wr;

  assign wsel       = reg_sel(rb.wr_addr);
  assign rsel       = reg_sel(rb.rd_addr);
  assign wval       = rb.wr_data & rb.wr_mask;
  assign status_wr  = rb.wr_en && (wsel == cfsr_pkg::CFSR_SEL_STATUS);
  assign restore_wr = rb.wr_en && (wsel == cfsr_pkg::CFSR_SEL_RESTORE);
  assign syn_wr     = rb.wr_en && (wsel == cfsr_pkg::CFSR_SEL_SYN);
  assign resume_wr  = rb.wr_en && (wsel == cfsr_pkg::CFSR_SEL_RESUME);
  assign cfg_wr     = rb.wr_en && (wsel == cfsr_pkg::CFSR_SEL_CFG);
  assign sbc_wr     = rb.wr_en && (wsel == cfsr_pkg::CFSR_SEL_SBC);
  assign ctl_wr     = rb.wr_en && (wsel == cfsr_pkg::CFSR_SEL_CTL);
  assign rb.wr_hit  = (wsel != cfsr_pkg::CFSR_SEL_NONE);
  assign rb.rd_hit  = (rsel != cfsr_pkg::CFSR_SEL_NONE);

  // ****************************************************************
  // bank configuration and control
  // ****************************************************************
  logic [3:0] cfg_q;
  logic [`CFSR_SBC_MSB:0] sbc_q;
  logic       retry_en_q;
  logic       sbc_new;
  logic       reconfig;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `CFSR_CFG_RST;
    end else if (cfg_wr) begin
      cfg_q <= wval[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sbc_q <= `CFSR_SBC_RST;
    end else if (sbc_wr) begin
      sbc_q <= wval[`CFSR_SBC_MSB:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retry_en_q <= 1'b0;
    end else if (ctl_wr) begin
      retry_en_q <= wval[`CFSR_CTL_RETRY_BIT];
    end
  end

  // same value written again does not count as a new bank count
  assign sbc_new  = sbc_wr && (wval[`CFSR_SBC_MSB:0] != sbc_q);
  assign reconfig = retry_en_q && (cfg_wr || sbc_new);

  // ****************************************************************
  // scheme code
  // ****************************************************************
  cfsr_pkg::cfsr_scheme_t scheme;

  // no check of bank kind, code is just computed
  cfsr_scheme_enc u_scheme (
    .wide_address_select     (cfg_q[`CFSR_CFG_WIDE_BIT]),
    .extended_address_enable (cfg_q[`CFSR_CFG_EAE_BIT]),
    .stage_two               (cfg_q[`CFSR_CFG_S2_BIT]),
    .scheme                  (scheme)
  );

  // ****************************************************************
  // fault flags
  // ****************************************************************
  // optional kinds read zero
  localparam logic [`CFSR_FLAG_MSB:1] IMPL = {2'h3, HAS_LOCK, HAS_MATCH, HAS_EXT, 3'h7};
  logic [`CFSR_FLAG_MSB:1] flag_w;
  logic multi_q;
  logic stall_q;
  logic any_rec;

  assign any_rec = (|flag_w) | multi_q | stall_q;

  // one flop per implemented flag; unsupported kinds read zero and ignore writes
  for (genvar i = 1; i <= `CFSR_FLAG_MSB; i++) begin : g_flag
    if (IMPL[i]) begin : g_impl
      logic bit_q;
      logic set;
      // fault sets its own kind bit
      assign set = fault_valid & fault_kind[i];
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          bit_q <= 1'b0;
        end else if (restore_wr) begin
          // restore value, a new fault still wins
          bit_q <= (bit_q & ~rb.wr_mask[i]) | wval[i] | set;
        end else begin
          bit_q <= (bit_q & ~(status_wr & wval[i])) | set;
        end
      end
      assign flag_w[i] = bit_q;
    end else begin : g_raz
      assign flag_w[i] = 1'b0;
    end
  end

  // second fault on a nonzero record
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      multi_q <= 1'b0;
    end else if (fault_valid && any_rec) begin
      multi_q <= 1'b1;
    end else if (restore_wr) begin
      multi_q <= (multi_q & ~rb.wr_mask[`CFSR_MULTI_BIT]) | wval[`CFSR_MULTI_BIT];
    end else if (status_wr && wval[`CFSR_MULTI_BIT]) begin
      multi_q <= 1'b0;
    end
  end

  // ****************************************************************
  // stall state
  // ****************************************************************
  // stalling fault marks the bank stalled
  // resume write is the normal way out
  // restore and status writes never touch it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stall_q <= 1'b0;
    end else if (fault_valid && fault_stall) begin
      stall_q <= 1'b1;
    end else if (resume_wr || reconfig) begin
      stall_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      context_stalled <= 1'b0;
    end else begin
      context_stalled <= stall_q;
    end
  end

  // written value picks resume or terminate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resume_pulse     <= 1'b0;
      resume_terminate <= 1'b0;
    end else begin
      resume_pulse <= resume_wr && stall_q;
      if (resume_wr && stall_q) begin
        resume_terminate <= wval[`CFSR_RESUME_TERM_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      retry_pulse <= 1'b0;
    end else begin
      retry_pulse <= reconfig && stall_q;
    end
  end

  // ****************************************************************
  // syndrome
  // ****************************************************************
  logic [BANK_IDX_W-1:0] syn_idx_q;
  logic syn_afr_q;
  logic syn_walk_q;
  logic nested;

  assign nested = cfg_q[`CFSR_CFG_NEST_BIT] & cfg_q[`CFSR_CFG_S2_BIT];

  // captured on the same edge as the flags
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syn_idx_q  <= '0;
      syn_afr_q  <= 1'b0;
      syn_walk_q <= 1'b0;
    end else if (fault_valid) begin
      // stage 1 bank only for nested translation
      syn_idx_q  <= nested ? fault_stage_one_bank : '0;
      syn_afr_q  <= fault_async;
      // walk flag needs an external fault
      syn_walk_q <= fault_walk & fault_kind[`CFSR_EXT_BIT] & IMPL[`CFSR_EXT_BIT];
    end else if (syn_wr) begin
      // only the implemented index bits are stored
      syn_idx_q  <= (syn_idx_q & ~rb.wr_mask[`CFSR_SYN_IDX_LSB +: BANK_IDX_W])
                    | wval[`CFSR_SYN_IDX_LSB +: BANK_IDX_W];
      syn_afr_q  <= (syn_afr_q & ~rb.wr_mask[`CFSR_SYN_AFR_BIT])
                    | wval[`CFSR_SYN_AFR_BIT];
      syn_walk_q <= (syn_walk_q & ~rb.wr_mask[`CFSR_SYN_WALK_BIT])
                    | wval[`CFSR_SYN_WALK_BIT];
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    rb.rd_data = 32'h0;
    unique case (rsel)
      cfsr_pkg::CFSR_SEL_STATUS: begin
        rb.rd_data[`CFSR_MULTI_BIT] = multi_q;
        rb.rd_data[`CFSR_STALL_BIT] = stall_q;
        // scheme code in the status word
        rb.rd_data[`CFSR_FMT_LSB +: 2] = scheme;
        rb.rd_data[`CFSR_FLAG_MSB:1] = flag_w;
      end
      cfsr_pkg::CFSR_SEL_SYN: begin
        rb.rd_data[`CFSR_SYN_IDX_LSB +: BANK_IDX_W] = syn_idx_q;
        rb.rd_data[`CFSR_SYN_AFR_BIT] = syn_afr_q;
        rb.rd_data[`CFSR_SYN_WALK_BIT] = syn_walk_q;
      end
      cfsr_pkg::CFSR_SEL_CFG: rb.rd_data[3:0] = cfg_q;
      cfsr_pkg::CFSR_SEL_SBC: rb.rd_data[`CFSR_SBC_MSB:0] = sbc_q;
      cfsr_pkg::CFSR_SEL_CTL: rb.rd_data[`CFSR_CTL_RETRY_BIT] = retry_en_q;
      default: rb.rd_data = 32'h0;
    endcase
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_multi_on_repeat: assert property (
    fault_valid && any_rec |=> multi_q ##1 (multi_q || $past(status_wr || restore_wr)))
    else $error("multi flag missed a repeated fault");

  a_stall_follows: assert property (
    fault_valid && fault_stall |=> stall_q ##1 context_stalled)
    else $error("stall flag not raised by a stalling fault");

  a_stall_clear_cause: assert property (
    $fell(stall_q) |-> $past(resume_wr || reconfig))
    else $error("stall flag dropped without resume or retry");

  a_stall_restore_keep: assert property (
    restore_wr && !fault_valid |=> stall_q == $past(stall_q))
    else $error("restore write changed the stall flag");

  a_retry_gated: assert property (
    retry_pulse |-> $past(retry_en_q) && (!stall_q || $past(fault_valid && fault_stall)))
    else $error("retry without enable or stall kept");

  a_scheme_stage2: assert property (
    cfg_q[`CFSR_CFG_S2_BIT] |-> scheme != cfsr_pkg::CFSR_FMT_SHORT)
    else $error("short scheme reported for stage 2");

  a_flags_capture: assert property (
    fault_valid |=> (flag_w & $past(fault_kind & IMPL)) == $past(fault_kind & IMPL))
    else $error("fault kind not recorded");

  a_w1c_clear: assert property (
    status_wr && wval[2] && !restore_wr && !(fault_valid && fault_kind[2]) |=> !flag_w[2])
    else $error("write one did not clear the flag");

  a_restore_load: assert property (
    restore_wr && !fault_valid && (&rb.wr_mask) |=> flag_w == ($past(wval[8:1]) & IMPL))
    else $error("restore did not load the flags");

  a_walk_only_ext: assert property (
    fault_valid |=> syn_walk_q == $past(fault_walk && fault_kind[`CFSR_EXT_BIT] && HAS_EXT))
    else $error("walk flag wrong for recorded fault");

  a_async_together: assert property (
    fault_valid |=> syn_afr_q == $past(fault_async) && (|flag_w || !$past(|(fault_kind & IMPL))))
    else $error("syndrome and flags not updated together");
endmodule : cfsr_fault_recorder

//--- cfsr_fault_src.sv
// upstream fault source model
`timescale 1ns/100ps
module cfsr_fault_src (
  // clock
  input  wire logic clock,
  // fault report
  output logic       fault_valid,
  output logic [8:1] fault_kind,
  output logic       fault_stall,
  output logic       fault_async,
  output logic       fault_walk,
  output logic [7:0] fault_stage_one_bank
);
  initial fault_valid = 1'b0;
  initial {fault_stall, fault_async, fault_walk, fault_kind, fault_stage_one_bank} = '0;
  // one pulse carries flags and syndrome
  task send(input logic [10:0] k, input logic [7:0] b);
    @(posedge clock);
    {fault_stall, fault_async, fault_walk, fault_kind} <= k;
    fault_stage_one_bank <= b;
    fault_valid <= 1'b1;
    @(posedge clock);
    fault_valid <= 1'b0;
    // idle payload inverted so stale values never look valid
    {fault_stall, fault_async, fault_walk, fault_kind, fault_stage_one_bank} <= ~{k, b};
  endtask : send
endmodule : cfsr_fault_src

//--- cfsr_map.svh
// offsets, field positions and reset values of the fault recorder
`ifndef CFSR_MAP_SVH
`define CFSR_MAP_SVH
`define CFSR_ADDR_W 8
`define CFSR_OFF_STATUS 8'h00
`define CFSR_OFF_RESTORE 8'h04
`define CFSR_OFF_SYN 8'h08
`define CFSR_OFF_RESUME 8'h0c
`define CFSR_OFF_CFG 8'h10
`define CFSR_OFF_SBC 8'h14
`define CFSR_OFF_CTL 8'h18
`define CFSR_MULTI_BIT 31
`define CFSR_STALL_BIT 30
`define CFSR_FMT_LSB 9
`define CFSR_FLAG_MSB 8
`define CFSR_EXT_BIT 4
`define CFSR_SYN_IDX_LSB 16
`define CFSR_SYN_AFR_BIT 11
`define CFSR_SYN_WALK_BIT 10
`define CFSR_CFG_WIDE_BIT 0
`define CFSR_CFG_EAE_BIT 1
`define CFSR_CFG_S2_BIT 2
`define CFSR_CFG_NEST_BIT 3
`define CFSR_SBC_MSB 7
`define CFSR_CTL_RETRY_BIT 0
`define CFSR_RESUME_TERM_BIT 0
`define CFSR_CFG_RST 4'h0
`define CFSR_SBC_RST 8'h00
`define CFSR_RESP_OKAY 2'h0
`define CFSR_RESP_SLVERR 2'h2
`endif

//--- cfsr_pkg.sv
// types shared by the fault recorder modules
package cfsr_pkg;
  typedef enum logic [1:0] {
    CFSR_FMT_SHORT = 2'h0,
    CFSR_FMT_LONG  = 2'h1,
    CFSR_FMT_WIDE  = 2'h2,
    CFSR_FMT_RSVD  = 2'h3
  } cfsr_scheme_t;
  typedef enum logic [7:0] {
    CFSR_SEL_NONE    = 8'h01,
    CFSR_SEL_STATUS  = 8'h02,
    CFSR_SEL_RESTORE = 8'h04,
    CFSR_SEL_SYN     = 8'h08,
    CFSR_SEL_RESUME  = 8'h10,
    CFSR_SEL_CFG     = 8'h20,
    CFSR_SEL_SBC     = 8'h40,
    CFSR_SEL_CTL     = 8'h80
  } cfsr_sel_t;
endpackage : cfsr_pkg

//--- cfsr_regbus_if.sv
// register strobes between the bus slave and the register file
`timescale 1ns/100ps
`include "cfsr_map.svh"
interface cfsr_regbus_if;
  logic                    wr_en;
  logic [`CFSR_ADDR_W-1:0] wr_addr;
  logic [31:0]             wr_data;
  logic [31:0]             wr_mask;
  logic                    wr_hit;
  logic [`CFSR_ADDR_W-1:0] rd_addr;
  logic [31:0]             rd_data;
  logic                    rd_hit;
  modport bus (output wr_en, wr_addr, wr_data, wr_mask, rd_addr,
               input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, wr_mask, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface : cfsr_regbus_if

//--- cfsr_scheme_enc.sv
// translation scheme code from the bank configuration
`timescale 1ns/100ps
module cfsr_scheme_enc (
  // configuration
  input  wire logic          wide_address_select,
  input  wire logic          extended_address_enable,
  input  wire logic          stage_two,
  // code
  output cfsr_pkg::cfsr_scheme_t scheme
);
  // stage 2 banks always use long descriptors at least
  always_comb begin
    if (wide_address_select) begin
      scheme = cfsr_pkg::CFSR_FMT_WIDE;
    end else if (extended_address_enable || stage_two) begin
      scheme = cfsr_pkg::CFSR_FMT_LONG;
    end else begin
      scheme = cfsr_pkg::CFSR_FMT_SHORT;
    end
  end
endmodule : cfsr_scheme_enc

//--- context_fault_status_recorder_bench.sv
// self-checking bench for the fault recorder
`timescale 1ns/100ps
module context_fault_status_recorder_bench;
  logic        clock, rst_n, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
  logic        s_axil_rready, fault_valid, fault_stall, fault_async, fault_walk;
  logic        context_stalled, resume_pulse, resume_terminate, retry_pulse;
  logic [7:0]  s_axil_awaddr, s_axil_araddr, fault_stage_one_bank;
  logic [31:0] s_axil_wdata, s_axil_rdata, rdat;
  logic [8:1]  fault_kind;
  logic [3:0]  s_axil_wstrb;
  logic [1:0]  s_axil_bresp, s_axil_rresp, resp;
  int          fails, checks, n_res, n_ret;

  cfsr_fault_src u_src (.clock, .fault_valid, .fault_kind, .fault_stall, .fault_async,
    .fault_walk, .fault_stage_one_bank);
  cfsr_fault_recorder u_dut (.clock, .rst_n, .s_axil_awvalid, .s_axil_awaddr,
    .s_axil_awready, .s_axil_wvalid, .s_axil_wdata, .s_axil_wstrb, .s_axil_wready,
    .s_axil_bvalid, .s_axil_bresp, .s_axil_bready, .s_axil_arvalid, .s_axil_araddr,
    .s_axil_arready, .s_axil_rvalid, .s_axil_rdata, .s_axil_rresp, .s_axil_rready,
    .fault_valid, .fault_kind, .fault_stall, .fault_async, .fault_walk,
    .fault_stage_one_bank, .context_stalled, .resume_pulse, .resume_terminate, .retry_pulse);

  initial clock = 1'b0;
  always #5 clock = ~clock;
  // pulses are one cycle wide, so count them as they pass
  always @(posedge clock) begin
    if (resume_pulse === 1'b1) n_res++;
    if (retry_pulse === 1'b1) n_ret++;
  end

  // ************
  // bus and check tasks
  // ************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_wstrb <= 4'hf;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    resp = s_axil_bresp;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clock);
    s_axil_araddr <= a;
    {s_axil_arvalid, s_axil_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    rdat = s_axil_rdata;
    resp = s_axil_rresp;
  endtask : rd

  // ************
  // scenarios
  // ************
  task t_reset;
    rd(8'h00);
    chk(rdat, 32'h0);
    rd(8'h1c);
    chk({rdat[31:2], resp}, 32'h2);
    wr(8'h1c, 32'h1);
    chk(32'(resp), 32'h2);
    $display("t_reset done");
  endtask : t_reset
  task t_flags;
    for (int i = 1; i <= 8; i++) begin
      u_src.send(11'h1 << (i - 1), 8'h00);
      rd(8'h00);
      chk(rdat, 32'h1 << i);
      wr(8'h00, 32'h1 << i);
      rd(8'h00);
      chk(rdat, 32'h0);
    end
    $display("t_flags done");
  endtask : t_flags
  task t_multi;
    u_src.send(11'h001, 8'h00);
    u_src.send(11'h004, 8'h00);
    rd(8'h00);
    chk(rdat, 32'h8000000a);
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk(rdat, 32'h8000000a);
    wr(8'h00, 32'h8000000a);
    rd(8'h00);
    chk(rdat, 32'h0);
    $display("t_multi done");
  endtask : t_multi
  task t_stall;
    u_src.send(11'h401, 8'h00);
    rd(8'h00);
    chk(rdat, 32'h40000002);
    chk(32'(context_stalled), 32'h1);
    wr(8'h00, 32'h40000002);
    rd(8'h00);
    chk(rdat, 32'h40000000);
    wr(8'h04, 32'h80000706);
    rd(8'h00);
    chk(rdat, 32'hc0000106);
    wr(8'h04, 32'h0);
    rd(8'h00);
    chk(rdat, 32'h40000000);
    wr(8'h0c, 32'h1);
    rd(8'h00);
    chk(rdat, 32'h0);
    chk({n_res[30:0], resume_terminate}, 32'h3);
    $display("t_stall done");
  endtask : t_stall
  task t_scheme;
    // configs 0,2,1,4,3 give codes 0,1,2,1,2
    for (int i = 0; i < 5; i++) begin
      wr(8'h10, 32'(20'h34120 >> (4 * i)) & 32'hf);
      rd(8'h00);
      chk(rdat, (32'(10'h264 >> (2 * i)) & 32'h3) << 9);
    end
    wr(8'h10, 32'h0);
    $display("t_scheme done");
  endtask : t_scheme
  task t_syn;
    wr(8'h10, 32'hc);
    u_src.send(11'h308, 8'h5a);
    rd(8'h08);
    chk(rdat, 32'h005a0c00);
    rd(8'h00);
    chk(rdat, 32'h00000210);
    wr(8'h00, 32'h10);
    u_src.send(11'h104, 8'h33);
    rd(8'h08);
    chk(rdat, 32'h00330000);
    wr(8'h00, 32'h80000008);
    wr(8'h10, 32'h0);
    $display("t_syn done");
  endtask : t_syn
  task t_retry;
    wr(8'h18, 32'h1);
    chk(32'(resp), 32'h0);
    u_src.send(11'h401, 8'h00);
    wr(8'h10, 32'h0);
    rd(8'h00);
    chk(rdat, 32'h00000002);
    chk(32'(n_ret), 32'h1);
    wr(8'h00, 32'h2);
    u_src.send(11'h400, 8'h00);
    wr(8'h14, 32'h0);
    rd(8'h00);
    chk(rdat, 32'h40000000);
    wr(8'h14, 32'h5);
    rd(8'h14);
    chk(rdat, 32'h5);
    rd(8'h00);
    chk(rdat, 32'h0);
    chk(32'(n_ret), 32'h2);
    wr(8'h0c, 32'h0);
    chk(32'(n_res), 32'h1);
    $display("t_retry done");
  endtask : t_retry

  task tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_n = 1'b0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata, s_axil_wstrb} = '0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_flags();
    t_multi();
    t_stall();
    t_scheme();
    t_syn();
    t_retry();
    tally_and_finish();
  end
  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule : context_fault_status_recorder_bench
